// *** bench/pscb_mac_model.sv ***
// MAC-side model: raises transmit enable on request and times collision.
// Assumes one clock shared with the block; a bit time is one cycle.
module pscb_mac_model (
    // Clock
    input  wire logic        sys_clk,
    // Request from the bench and collision from the block
    input  wire logic        tx_go,
    input  wire logic        mac_col,
    // Transmit enable and measured delays in cycles
    output logic             mac_tx_en,
    output logic [15:0]      col_on_wait,
    output logic [15:0]      col_off_wait
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        mac_tx_en = 1'b0;
        col_on_wait = 16'h0000;
        col_off_wait = 16'h0000;
    end

    always @(posedge sys_clk)
    begin
        mac_tx_en <= tx_go;
        if (mac_tx_en && !mac_col)
            col_on_wait <= col_on_wait + 16'h0001;
        else if (!mac_tx_en && !mac_col)
            col_on_wait <= 16'h0000;
        if (!mac_tx_en && mac_col)
            col_off_wait <= col_off_wait + 16'h0001;
        else if (mac_tx_en && mac_col)
            col_off_wait <= 16'h0000;
    end
endmodule

// *** bench/pscb_strap_ctrl_test.sv ***
// Self-checking bench for the strap loader and basic mode control.
// Assumes the design package, the design module and the MAC model.
module pscb_strap_ctrl_test
    import pscb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Signals and strap table
    // ----------------------------------------
    localparam logic [10:0] SP [8] = '{11'h000, 11'h7F5, 11'h280, 11'h500,
                                       11'h087, 11'h250, 11'h510, 11'h008};
    localparam logic [13:0] SC [8] = '{14'h004E, 14'h2CB6, 14'h010E,
        14'h024E, 14'h084E, 14'h2241, 14'h1440, 14'h0640};
    localparam logic [15:0] BM [8] = '{16'h3100, 16'h2100, 16'h3100,
        16'h3100, 16'h3100, 16'h0400, 16'h0000, 16'h0000};
    localparam logic [4:0]  OV [8] = '{5'h0E, 5'h06, 5'h0E, 5'h1E,
                                       5'h0E, 5'h01, 5'h00, 5'h00};
    logic          sys_clk = 1'b0;
    logic          srst = 1'b1;
    logic [10:0]   strap_pins = 11'h000;
    logic          enhanced_mode = 1'b1;
    logic          interrupt_powerdown_pin_n = 1'b1;
    logic          reg_stb = 1'b0;
    pscb_reg_req_s reg_req = '0;
    logic          tx_go = 1'b0;
    logic [15:0]   reg_rdata, col_on_wait, col_off_wait;
    pscb_strap_s   strap_cfg;
    logic          reference_clock_enable, rmii_clock_enable, loopback;
    logic          power_down, mac_isolate, link_speed_100, link_full_duplex;
    logic          autoneg_enable, autoneg_restart, soft_reset_busy;
    logic          mac_tx_en, mac_col;
    int            bad_count = 0;
    int            n_compared = 0;
    wire logic [4:0] ov_seen = {rmii_clock_enable, autoneg_enable,
        link_speed_100, link_full_duplex, mac_isolate};
    wire logic [5:0] ctl_seen = {loopback, power_down, mac_isolate,
        link_speed_100, link_full_duplex, autoneg_enable};

    always #5 sys_clk = ~sys_clk;

    pscb_strap_ctrl DUT (
        .sys_clk                   (sys_clk),
        .srst                      (srst),
        .strap_pins                (strap_pins),
        .enhanced_mode             (enhanced_mode),
        .interrupt_powerdown_pin_n (interrupt_powerdown_pin_n),
        .reg_stb                   (reg_stb),
        .reg_req                   (reg_req),
        .reg_rdata                 (reg_rdata),
        .strap_cfg                 (strap_cfg),
        .reference_clock_enable    (reference_clock_enable),
        .rmii_clock_enable         (rmii_clock_enable),
        .loopback                  (loopback),
        .power_down                (power_down),
        .mac_isolate               (mac_isolate),
        .link_speed_100            (link_speed_100),
        .link_full_duplex          (link_full_duplex),
        .autoneg_enable            (autoneg_enable),
        .autoneg_restart           (autoneg_restart),
        .soft_reset_busy           (soft_reset_busy),
        .mac_tx_en                 (mac_tx_en),
        .mac_col                   (mac_col)
    );

    pscb_mac_model mac (
        .sys_clk      (sys_clk),
        .tx_go        (tx_go),
        .mac_col      (mac_col),
        .mac_tx_en    (mac_tx_en),
        .col_on_wait  (col_on_wait),
        .col_off_wait (col_off_wait)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic hw_reset(input logic [10:0] s, input logic e);
        @(posedge sys_clk);
        #1;
        srst = 1'b1;
        strap_pins = s;
        enhanced_mode = e;
        repeat (5) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic reg_io(input logic we, input logic [4:0] a,
                          input logic [15:0] wd, output logic [15:0] rd);
        @(posedge sys_clk);
        #1;
        reg_stb = 1'b1;
        reg_req = '{we, a, wd};
        @(posedge sys_clk);
        #1;
        rd = reg_rdata;
        reg_stb = 1'b0;
    endtask

    task automatic wait_cycles(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic count_restart(output int n);
        n = 0;
        repeat (8)
        begin
            n += int'(autoneg_restart === 1'b1);
            wait_cycles(1);
        end
    endtask

    task automatic wait_col(input logic v);
        for (int k = 0; k < 600 && mac_col !== v; k++)
            wait_cycles(1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_straps();
        logic [15:0] rv;
        for (int i = 0; i < 8; i++)
        begin
            hw_reset(SP[i], i < 4);
            check(16'(strap_cfg[13:7]),
                  16'(SC[i][13:7]));
            check(16'(strap_cfg[6:0]),
                  16'(SC[i][6:0]));
            check(16'(ov_seen), 16'(OV[i]));
            if (i < 4)
                check(16'(reference_clock_enable), 16'(!SC[i][4]));
            reg_io(1'b0, 5'h00, 16'h0000, rv);
            check(rv, BM[i]);
        end
    endtask

    task automatic t_regs();
        logic [15:0] rv;
        int n;
        hw_reset(11'h000, 1'b1);
        reg_io(1'b1, 5'h00, 16'h6DFF, rv);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h6D80);
        check(16'(ctl_seen), 16'h003E);
        reg_io(1'b1, 5'h02, 16'hFFFF, rv);
        reg_io(1'b0, 5'h02, 16'h0000, rv);
        check(rv, 16'h0000);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h6D80);
        reg_io(1'b1, 5'h00, 16'h3300, rv);
        count_restart(n);
        check(16'(n), 16'h0001);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h3100);
        reg_io(1'b1, 5'h00, 16'h0200, rv);
        count_restart(n);
        check(16'(n), 16'h0000);
    endtask

    task automatic t_soft();
        logic [15:0] rv;
        int n;
        hw_reset(11'h085, 1'b0);
        reg_io(1'b1, 5'h00, 16'h6000, rv);
        strap_pins = 11'h000;
        reg_io(1'b1, 5'h00, 16'h8000, rv);
        check(16'(soft_reset_busy), 16'h0001);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h9100);
        for (n = 0; n < 40 && soft_reset_busy === 1'b1; n++)
            wait_cycles(1);
        check(16'(n < 40), 16'h0001);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h1100);
        check(16'(strap_cfg.mgmt_addr), 16'h0001);
        interrupt_powerdown_pin_n = 1'b0;
        wait_cycles(4);
        check(16'(power_down), 16'h0001);
        reg_io(1'b1, 5'h00, 16'h1100, rv);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h1900);
        interrupt_powerdown_pin_n = 1'b1;
        wait_cycles(4);
        reg_io(1'b0, 5'h00, 16'h0000, rv);
        check(rv, 16'h1900);
        reg_io(1'b1, 5'h00, 16'h1100, rv);
        wait_cycles(1);
        check(16'(power_down), 16'h0000);
    endtask

    task automatic t_col();
        logic [15:0] rv;
        reg_io(1'b1, 5'h00, 16'h2080, rv);
        tx_go = 1'b1;
        wait_col(1'b1);
        check(16'(mac_col), 16'h0001);
        check(16'(col_on_wait <= 16'h0200), 16'h0001);
        tx_go = 1'b0;
        wait_col(1'b0);
        check(16'(col_off_wait <= 16'h0004), 16'h0001);
        reg_io(1'b1, 5'h00, 16'h2000, rv);
        tx_go = 1'b1;
        wait_col(1'b1);
        check(16'(mac_col), 16'h0000);
        tx_go = 1'b0;
    endtask

    task automatic finish_test();
        $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        t_straps();
        t_regs();
        t_soft();
        t_col();
        finish_test();
    end

    initial
    begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule

// *** design/pscb_cfg.svh ***
// Constants for the strap loader and basic mode control register.
// Assumes inclusion by bare name from the design module.
`ifndef PSCB_CFG_SVH
`define PSCB_CFG_SVH
`define PSCB_BMC_OFFSET      5'h00
`define PSCB_BMC_RESET       16'h3100
`define PSCB_BIT_SOFT_RESET  15
`define PSCB_BIT_LOOPBACK    14
`define PSCB_BIT_SPEED       13
`define PSCB_BIT_AUTONEG     12
`define PSCB_BIT_POWERDOWN   11
`define PSCB_BIT_ISOLATE     10
`define PSCB_BIT_RESTART     9
`define PSCB_BIT_DUPLEX      8
`define PSCB_BIT_COLTEST     7
`define PSCB_RSVD_MASK       16'hFF80
`define PSCB_CLK_MHZ         100
`define PSCB_BIT_NS_100M     10
`define PSCB_BIT_NS_10M      100
`define PSCB_COL_ON_BITS     512
`define PSCB_COL_OFF_BITS    4
`define PSCB_SRST_CYCLES     8'h10
`define PSCB_MODE_MII        3'h0
`define PSCB_MODE_RMII_MST   3'h1
`define PSCB_MODE_RMII_SLV   3'h5
`endif

// *** design/pscb_pkg.sv ***
// Types shared by the strap loader and basic mode control logic.
// Assumes no other file; the constants header is not included here.
package pscb_pkg;
    typedef enum logic [1:0] {
        PSCB_MAC_MII      = 2'h0,
        PSCB_MAC_RMII_MST = 2'h1,
        PSCB_MAC_RMII_SLV = 2'h2,
        PSCB_MAC_RSVD     = 2'h3
    } pscb_mac_e;

    typedef enum logic [2:0] {
        PSCB_SR_IDLE = 3'b001,
        PSCB_SR_BUSY = 3'b010,
        PSCB_SR_DONE = 3'b100
    } pscb_sr_e;

    typedef struct packed {
        logic [2:0] mgmt_addr;
        pscb_mac_e  mac_mode;
        logic       fast_link_drop;
        logic       repeater_receive_valid;
        logic       auto_mdix;
        logic       pair_straight;
        logic       second_indicator_sel;
        logic       autoneg;
        logic       speed_100;
        logic       full_duplex;
        logic       isolate;
    } pscb_strap_s;

    typedef struct packed {
        logic        we;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pscb_reg_req_s;

    typedef struct packed {
        logic [10:0] strap_meta;
        logic [10:0] strap_sync;
        logic        mode_meta;
        logic        mode_sync;
        logic        pwdn_meta;
        logic        pwdn_sync;
        logic        txen_meta;
        logic        txen_sync;
        logic        latched;
        pscb_strap_s strap;
        logic [15:0] bmc;
        pscb_sr_e    sr_state;
        logic [7:0]  sr_cnt;
        logic        an_restart_pulse;
        logic [13:0] col_cnt;
        logic        col;
        logic [15:0] rdata;
    } pscb_state_s;
endpackage

// *** design/pscb_strap_ctrl.sv ***
// Strap loader and basic mode control register of a 10/100 Ethernet PHY.
// Assumes straps, pin-mode select, power-down pin and transmit enable come
// from outside the clock domain; register access is a simple strobe port.
//
// Overview of operation
// - Enhanced mode: address bits from three straps, default zero.
// - Enhanced mode: MAC-select strap 0 gives MII, 1 gives RMII.
// - Enhanced MII: fast link-drop strap 1 enables, 0 disables.
// - Enhanced RMII: strap 0 means clock master, 1 means slave.
// - Enhanced RMII: strap 1 makes receive valid a repeater output.
// - Enhanced: crossover and negotiation on by default; strap 1 disables.
// - Crossover off: pair strap 0 crossed, 1 straight; ignored otherwise.
// - Enhanced: clock-output strap 0 gives 25 MHz clock, 1 second indicator.
// - Basic mode: address from other straps, default address bit 0 set.
// - Basic mode: three straps pick MII, RMII master or slave.
// - Basic mode: straps set negotiation, speed and duplex, default all one.
// - Basic mode: isolate strap 1 starts MAC interface isolated.
// - Soft reset bit reloads standard settings, reads one, then self-clears.
// - Loopback bit routes transmit to receive; manager sets self-test field.
// - Negotiation off: speed and duplex bits set the link mode.
// - Negotiation bit loads from strap; when set, speed and duplex ignored.
// - Power-down bit ORed with active-low pin; pin assertion sets the bit.
// - Isolate cuts MAC interface, stops RMII master clock; basic mode strap.
// - Restart bit restarts negotiation, reads one until taken, then clears.
// - Collision test asserts collision within 512, drops within 4 bit times.
// - Straps sampled at hard reset; soft reset reloads the latched copy.
module pscb_strap_ctrl
    import pscb_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          srst,
    // Strap pins and pin mode
    input  wire logic [10:0]   strap_pins,
    input  wire logic          enhanced_mode,
    input  wire logic          interrupt_powerdown_pin_n,
    // Register access
    input  wire logic          reg_stb,
    input  pscb_reg_req_s      reg_req,
    output logic [15:0]        reg_rdata,
    // Decoded configuration
    output pscb_strap_s        strap_cfg,
    output logic               reference_clock_enable,
    output logic               rmii_clock_enable,
    // Control outputs
    output logic               loopback,
    output logic               power_down,
    output logic               mac_isolate,
    output logic               link_speed_100,
    output logic               link_full_duplex,
    output logic               autoneg_enable,
    output logic               autoneg_restart,
    output logic               soft_reset_busy,
    // Collision test
    input  wire logic          mac_tx_en,
    output logic               mac_col
);
`include "pscb_cfg.svh"

    // Bit time counts: 100 Mbps is the fastest, 10 Mbps the slowest.
    localparam int COL_ON_CYC  = `PSCB_COL_ON_BITS * `PSCB_BIT_NS_100M
                                 * `PSCB_CLK_MHZ / 1000;
    localparam int COL_OFF_CYC = `PSCB_COL_OFF_BITS * `PSCB_BIT_NS_100M
                                 * `PSCB_CLK_MHZ / 1000;
    localparam int COL_DLY     = COL_ON_CYC / 2;
    localparam int SR_CYC      = 16;

    pscb_state_s s_q;
    pscb_state_s s_d;

    function automatic pscb_strap_s decode_straps(input logic [10:0] p,
                                                  input logic enh);
        pscb_strap_s r;
        logic [2:0]  sel;
        r   = '0;
        sel = {p[10], p[3], p[4]};
        if (enh)
        begin
            r.mgmt_addr = {p[4], p[3], p[2]};
            if (!p[8])
                r.mac_mode = PSCB_MAC_MII;
            else if (!p[5])
                r.mac_mode = PSCB_MAC_RMII_MST;
            else
                r.mac_mode = PSCB_MAC_RMII_SLV;
            r.fast_link_drop = !p[8] && p[7];
            r.repeater_receive_valid = p[8] && p[7];
            r.auto_mdix = !p[9];
            r.autoneg   = !p[0];
            r.speed_100 = 1'b1;
            r.full_duplex = 1'b1;
            r.pair_straight = p[9] && p[10];
            r.second_indicator_sel = p[6];
            r.isolate = 1'b0;
        end
        else
        begin
            r.mgmt_addr = {p[9], p[8], p[7]};
            case (sel)
                `PSCB_MODE_MII:      r.mac_mode = PSCB_MAC_MII;
                `PSCB_MODE_RMII_MST: r.mac_mode = PSCB_MAC_RMII_MST;
                `PSCB_MODE_RMII_SLV: r.mac_mode = PSCB_MAC_RMII_SLV;
                default:             r.mac_mode = PSCB_MAC_RSVD;
            endcase
            r.autoneg     = p[2];
            r.speed_100   = p[1];
            r.full_duplex = p[0];
            r.isolate   = p[6];
            r.auto_mdix = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [15:0] strap_bmc(input pscb_strap_s st);
        logic [15:0] v;
        v = `PSCB_BMC_RESET;
        v[`PSCB_BIT_AUTONEG] = st.autoneg;
        v[`PSCB_BIT_SPEED]   = st.speed_100;
        v[`PSCB_BIT_DUPLEX]  = st.full_duplex;
        v[`PSCB_BIT_ISOLATE] = st.isolate;
        return v;
    endfunction

    logic wr_hit;
    assign wr_hit = reg_stb && reg_req.we
                    && reg_req.addr == `PSCB_BMC_OFFSET;

    always_comb
    begin
        s_d = s_q;
        s_d.strap_meta = strap_pins;
        s_d.strap_sync = s_q.strap_meta;
        s_d.mode_meta  = enhanced_mode;
        s_d.mode_sync  = s_q.mode_meta;
        s_d.pwdn_meta  = !interrupt_powerdown_pin_n;
        s_d.pwdn_sync  = s_q.pwdn_meta;
        s_d.txen_meta  = mac_tx_en;
        s_d.txen_sync  = s_q.txen_meta;
        s_d.an_restart_pulse = 1'b0;
        if (!s_q.latched)
        begin
            s_d.latched = 1'b1;
            s_d.strap   = decode_straps(s_q.strap_sync, s_q.mode_sync);
            s_d.bmc     = strap_bmc(s_d.strap);
        end
        else
        begin
            if (wr_hit)
            begin
                s_d.bmc = reg_req.wdata & `PSCB_RSVD_MASK;
                s_d.bmc[`PSCB_BIT_SOFT_RESET] = 1'b0;
                s_d.bmc[`PSCB_BIT_RESTART] = s_q.bmc[`PSCB_BIT_RESTART]
                                 | reg_req.wdata[`PSCB_BIT_RESTART];
            end
            if (s_q.bmc[`PSCB_BIT_RESTART])
            begin
                s_d.bmc[`PSCB_BIT_RESTART] = wr_hit
                                 && reg_req.wdata[`PSCB_BIT_RESTART];
                s_d.an_restart_pulse = s_q.bmc[`PSCB_BIT_AUTONEG];
            end
            case (s_q.sr_state)
                PSCB_SR_IDLE:
                    if (wr_hit && reg_req.wdata[`PSCB_BIT_SOFT_RESET])
                    begin
                        s_d.sr_state = PSCB_SR_BUSY;
                        s_d.sr_cnt   = `PSCB_SRST_CYCLES;
                        s_d.bmc      = strap_bmc(s_q.strap);
                        s_d.bmc[`PSCB_BIT_SOFT_RESET] = 1'b1;
                    end
                PSCB_SR_BUSY:
                begin
                    s_d.bmc = strap_bmc(s_q.strap);
                    s_d.bmc[`PSCB_BIT_SOFT_RESET] = 1'b1;
                    s_d.sr_cnt = s_q.sr_cnt - 8'h01;
                    if (s_q.sr_cnt == 8'h01)
                        s_d.sr_state = PSCB_SR_DONE;
                end
                PSCB_SR_DONE:
                begin
                    s_d.bmc[`PSCB_BIT_SOFT_RESET] = 1'b0;
                    s_d.sr_state = PSCB_SR_IDLE;
                end
                default: s_d.sr_state = PSCB_SR_IDLE;
            endcase
            if (s_q.pwdn_sync)
                s_d.bmc[`PSCB_BIT_POWERDOWN] = 1'b1;
        end
        if (s_q.bmc[`PSCB_BIT_COLTEST] && s_q.txen_sync)
        begin
            if (s_q.col_cnt < 14'(COL_DLY))
                s_d.col_cnt = s_q.col_cnt + 14'h0001;
            else
                s_d.col = 1'b1;
        end
        else
        begin
            s_d.col_cnt = '0;
            s_d.col     = 1'b0;
        end
        s_d.rdata = (reg_stb && !reg_req.we
                     && reg_req.addr == `PSCB_BMC_OFFSET) ? s_q.bmc : '0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            // Straps keep flowing through the synchroniser during reset, so
            // the first clock after release latches the real pin levels.
            s_q            <= '0;
            s_q.sr_state   <= PSCB_SR_IDLE;
            s_q.bmc        <= `PSCB_BMC_RESET;
            s_q.strap_meta <= s_d.strap_meta;
            s_q.strap_sync <= s_d.strap_sync;
            s_q.mode_meta  <= s_d.mode_meta;
            s_q.mode_sync  <= s_d.mode_sync;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata        = s_q.rdata;
    assign strap_cfg        = s_q.strap;
    assign loopback         = s_q.bmc[`PSCB_BIT_LOOPBACK];
    assign power_down       = s_q.bmc[`PSCB_BIT_POWERDOWN] | s_q.pwdn_sync;
    assign mac_isolate      = s_q.bmc[`PSCB_BIT_ISOLATE];
    assign rmii_clock_enable = s_q.strap.mac_mode == PSCB_MAC_RMII_MST
                               && !s_q.bmc[`PSCB_BIT_ISOLATE];
    assign reference_clock_enable = !s_q.strap.second_indicator_sel;
    assign autoneg_enable   = s_q.bmc[`PSCB_BIT_AUTONEG];
    assign link_speed_100   = s_q.bmc[`PSCB_BIT_AUTONEG]
                              | s_q.bmc[`PSCB_BIT_SPEED];
    assign link_full_duplex = s_q.bmc[`PSCB_BIT_AUTONEG]
                              | s_q.bmc[`PSCB_BIT_DUPLEX];
    assign autoneg_restart  = s_q.an_restart_pulse;
    assign soft_reset_busy  = s_q.bmc[`PSCB_BIT_SOFT_RESET];
    assign mac_col          = s_q.col;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence sr_start_s;
        s_q.latched && wr_hit && reg_req.wdata[15]
        && s_q.sr_state == PSCB_SR_IDLE;
    endsequence

    soft_reset_seq_a: assert property (sr_start_s
                                       |=> soft_reset_busy[*8])
        else $error("soft reset bit did not hold");
    rsvd_zero_a: assert property (s_q.bmc[6:0] == 7'h00)
        else $error("reserved bits not zero");
    pwdn_or_a: assert property (s_q.pwdn_sync |-> power_down)
        else $error("power-down pin not honoured");
    pwdn_set_a: assert property (s_q.pwdn_sync && s_q.latched
                                 |=> s_q.bmc[11])
        else $error("power-down bit not set by pin");
    restart_clear_a: assert property (s_q.bmc[9] && s_q.latched
                                      |=> autoneg_restart
                                          == $past(s_q.bmc[12]))
        else $error("restart pulse wrong");
    an_ignore_a: assert property (autoneg_enable |-> link_speed_100
                                  && link_full_duplex)
        else $error("speed bits not ignored");
    col_on_a: assert property ($rose(s_q.txen_sync && s_q.bmc[7])
                               |-> ##[1:300] mac_col)
        else $error("collision late");
    col_off_a: assert property ($fell(s_q.txen_sync) |=> !mac_col)
        else $error("collision not dropped");
    iso_clk_a: assert property (mac_isolate |-> !rmii_clock_enable)
        else $error("clock not stopped on isolate");
    latch_once_a: assert property (s_q.latched |=> $stable(strap_cfg))
        else $error("straps resampled");
    sr_reload_a: assert property (sr_start_s
                                  |=> s_q.bmc[12] == s_q.strap.autoneg)
        else $error("soft reset did not reload straps");
    col_clear_a: assert property (!s_q.bmc[7] |=> !mac_col)
        else $error("collision without test bit");
endmodule
